// ### logic/hdl_link.sv
// The implementer's own choices: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
// Contract
// R1 - bit rates 300 to 38400 baud selectable
// R2 - parity none/even, check crc or sum, node address 0 to 254
// R3 - line modes: plain, modem rts/cts, two-wire network; two-wire network acts as plain mode, rts stays low
// R4 - suppression on and nothing queued: no reply to a poll
// R5 - duplicate detect on: repeated packet is dropped, not answered
// R6 - poll timeout 0 to 65535 units of 20 ms
// R7 - poll timeout runs only while own message request pending
// R8 - poll timeout expiry flags error and drops pending request
// R9 - poll timeout zero disables it
// R10 - rts held for off delay after last character, 20 ms units
// R11 - after rts, wait send delay before sampling cts
// R12 - resend unacknowledged packet up to retry count 0 to 255
// R13 - plain mode: pre-transmit delay in 1 ms units before sending
// R14 - modem mode: pre-transmit delay after last rx char before rts
// R15 - master polls and acknowledges each good slave packet
module hdl_link (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic cts,
  output logic rts,
  output logic txd,
  output logic irq
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [31:0] ctrl_reg;
  logic [15:0] poll_to_reg, rts_off_reg, rts_send_reg, pre_tx_reg;
  logic [7:0] tx_data_reg, rx_data_reg, last_rx_reg;
  logic [15:0] last_sig_reg;
  logic last_sig_ok_reg;
  localparam int I_W_L = hdl_pkg::I_W;
  logic [I_W_L-1:0] istat_reg, imask_reg;
  logic msg_pend_reg;
  logic sent_wait_reg;
  logic [7:0] retry_reg;
  logic [15:0] poll_cnt_reg, dly_reg;
  hdl_pkg::hdl_st_t st_reg;
  logic wr_ph_reg;
  logic [7:0] wa_reg;
  logic [31:0] rdata_reg;
  hdl_pkg::hdl_byte_t txb;
  logic tx_busy;
  logic tick1, tick20, tickp;
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // baud select to cycles per bit; 300 baud needs 18 bits at this clock
  function automatic logic [17:0] baud_div(input logic [2:0] sel);
    logic [31:0] rate;
    rate = 32'd300 << sel;
    if (sel == 3'h6) rate = 32'd19200;
    if (sel == 3'h7) rate = 32'd38400;
    return 18'((hdl_pkg::CLK_HZ / rate) - 1);
  endfunction
  // packet signature: crc-ish fold or plain sum, per check mode
  function automatic logic [15:0] sig(input logic crc, input logic [15:0] s,
                                      input logic [7:0] d);
    if (crc) return {s[14:0], 1'b0} ^ (s[15] ? 16'h8005 : 16'h0000) ^ {8'h00, d};
    return s + {8'h00, d};
  endfunction
  wire [2:0] baud_sel = ctrl_reg[hdl_pkg::C_BAUD_LSB +: 3]; // R1
  wire par_en = ctrl_reg[hdl_pkg::C_PAR]; // R2
  wire chk_crc = ctrl_reg[hdl_pkg::C_CHK]; // R2
  wire [1:0] line = ctrl_reg[hdl_pkg::C_LINE_LSB +: 2]; // R3
  wire eot_sup = ctrl_reg[hdl_pkg::C_EOT_SUP];
  wire dup_en = ctrl_reg[hdl_pkg::C_DUP];
  wire [7:0] node_addr = ctrl_reg[hdl_pkg::C_ADDR_LSB +: 8];
  wire [7:0] retry_max = ctrl_reg[hdl_pkg::C_RETRY_LSB +: 8];
  wire modem = (line == 2'(hdl_pkg::LINE_MODEM));
  // ----------------------------------------------------------------
  // ahb decode
  // ----------------------------------------------------------------
  wire addr_ph = hsel && hready && htrans[1];
  wire rd_ph = addr_ph && !hwrite;
  wire wr = wr_ph_reg;
  wire [7:0] wa = wa_reg;
  wire cmd_wr = wr && (wa == hdl_pkg::A_CMD);
  wire do_msg = cmd_wr && hwdata[hdl_pkg::K_MSG];
  wire do_ack = cmd_wr && hwdata[hdl_pkg::K_ACK];
  wire do_poll = cmd_wr && hwdata[hdl_pkg::K_POLL];
  wire do_rxpkt = cmd_wr && hwdata[hdl_pkg::K_RXPKT];
  wire [7:0] ra = haddr[7:0];
  wire [15:0] rx_sig = sig(chk_crc, {8'h00, node_addr}, hwdata[15:8]);
  wire is_dup = dup_en && last_sig_ok_reg && (rx_sig == last_sig_reg); // R5
  wire [31:0] rd_mux =
    (ra == hdl_pkg::A_CTRL) ? ctrl_reg :
    (ra == hdl_pkg::A_POLL_TO) ? {16'h0000, poll_to_reg} :
    (ra == hdl_pkg::A_RTS_OFF) ? {16'h0000, rts_off_reg} :
    (ra == hdl_pkg::A_RTS_SEND) ? {16'h0000, rts_send_reg} :
    (ra == hdl_pkg::A_PRE_TX) ? {16'h0000, pre_tx_reg} :
    (ra == hdl_pkg::A_TX_DATA) ? {24'h00_0000, tx_data_reg} :
    (ra == hdl_pkg::A_RX_DATA) ? {24'h00_0000, rx_data_reg} :
    (ra == hdl_pkg::A_STATUS) ? {16'h0000, retry_reg, 3'h0, tx_busy, rts,
                                st_reg} :
    (ra == hdl_pkg::A_IRQ_STAT) ? {27'h000_0000, istat_reg} :
    (ra == hdl_pkg::A_IRQ_MASK) ? {27'h000_0000, imask_reg} : 32'h0000_0000;
  // ----------------------------------------------------------------
  // bus pipeline
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ph_reg <= 1'b0;
      wa_reg <= 8'h00;
      rdata_reg <= 32'h0000_0000;
    end else begin
      wr_ph_reg <= addr_ph && hwrite;
      wa_reg <= haddr[7:0];
      if (rd_ph) rdata_reg <= rd_mux;
    end
  end
  assign hrdata = rdata_reg;
  assign hreadyout = 1'b1; // zero wait states
  assign hresp = 1'b0;
  // ----------------------------------------------------------------
  // configuration writes
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= hdl_pkg::CTRL_RST;
      poll_to_reg <= 16'h0000;
      rts_off_reg <= 16'h0000;
      rts_send_reg <= 16'h0000;
      pre_tx_reg <= 16'h0000;
      tx_data_reg <= 8'h00;
      imask_reg <= 5'h00;
    end else if (wr) begin
      if (wa == hdl_pkg::A_CTRL) begin
        // node address stops at 254
        ctrl_reg <= {hwdata[31:24], hwdata[23:16] == 8'hFF ? 8'hFE : hwdata[23:16],
                     7'h00, hwdata[8:0]}; // R2
      end
      if (wa == hdl_pkg::A_POLL_TO) poll_to_reg <= hwdata[15:0]; // R6
      if (wa == hdl_pkg::A_RTS_OFF) rts_off_reg <= hwdata[15:0];
      if (wa == hdl_pkg::A_RTS_SEND) rts_send_reg <= hwdata[15:0];
      if (wa == hdl_pkg::A_PRE_TX) pre_tx_reg <= hwdata[15:0];
      if (wa == hdl_pkg::A_TX_DATA) tx_data_reg <= hwdata[7:0];
      if (wa == hdl_pkg::A_IRQ_MASK) imask_reg <= hwdata[4:0];
    end
  end
  // ----------------------------------------------------------------
  // transmit sequencer
  // ----------------------------------------------------------------
  // a poll starts a reply only when a message is queued or no suppression
  wire reply = do_poll && !tx_busy && (st_reg == hdl_pkg::ST_IDLE) &&
               (msg_pend_reg || !eot_sup); // R4
  // expiry fires only while a request waits and timeout is nonzero
  wire poll_run = msg_pend_reg && (poll_to_reg != 16'h0000); // R7 R9
  wire poll_exp = poll_run && tickp && (poll_cnt_reg == 16'h0001); // R8
  wire no_ack_retry = msg_pend_reg && sent_wait_reg && do_poll;
  wire dly_done = (dly_reg == 16'h0000);
  wire send_done = (st_reg == hdl_pkg::ST_SEND) && !tx_busy && !txb.valid;
  // unit ticks restart whenever their delay is loaded
  wire load20 = modem && ((st_reg == hdl_pkg::ST_PRE && dly_done) || send_done);
  hdl_tick #(.DIV(hdl_pkg::CYC_1MS)) u_t1 (
    .hclk(hclk), .hresetn(hresetn), .restart(reply), .tick(tick1)); // R13 R14
  hdl_tick #(.DIV(hdl_pkg::CYC_20MS)) u_t20 (
    .hclk(hclk), .hresetn(hresetn), .restart(load20), .tick(tick20)); // R10 R11
  hdl_tick #(.DIV(hdl_pkg::CYC_20MS)) u_tp (
    .hclk(hclk), .hresetn(hresetn), .restart(do_msg || do_poll), .tick(tickp)); // R6
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= hdl_pkg::ST_IDLE;
      dly_reg <= 16'h0000;
    end else begin
      unique case (st_reg)
        hdl_pkg::ST_IDLE: begin
          if (reply) begin
            st_reg <= hdl_pkg::ST_PRE;
            dly_reg <= pre_tx_reg; // R13 R14
          end
        end
        hdl_pkg::ST_PRE: begin
          // modem: counted from last rx char, which the poll marks
          if (dly_done) begin
            st_reg <= modem ? hdl_pkg::ST_RTS_WAIT : hdl_pkg::ST_SEND; // R13 R14
            dly_reg <= rts_send_reg;
          end else if (tick1) begin
            dly_reg <= dly_reg - 16'h0001;
          end
        end
        hdl_pkg::ST_RTS_WAIT: begin
          if (dly_done) st_reg <= hdl_pkg::ST_CTS; // R11
          else if (tick20) dly_reg <= dly_reg - 16'h0001;
        end
        hdl_pkg::ST_CTS: begin
          if (cts) st_reg <= hdl_pkg::ST_SEND; // R11
        end
        hdl_pkg::ST_SEND: begin
          if (send_done) begin
            st_reg <= modem ? hdl_pkg::ST_RTS_OFF : hdl_pkg::ST_IDLE;
            dly_reg <= rts_off_reg; // R10
          end
        end
        hdl_pkg::ST_RTS_OFF: begin
          if (dly_done) st_reg <= hdl_pkg::ST_IDLE; // R10
          else if (tick20) dly_reg <= dly_reg - 16'h0001;
        end
        default: st_reg <= hdl_pkg::ST_IDLE;
      endcase
    end
  end
  // one character per reply: message byte, or the empty-reply marker
  logic issued_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      issued_reg <= 1'b0;
    end else begin
      issued_reg <= (st_reg == hdl_pkg::ST_SEND) && (issued_reg || !tx_busy);
    end
  end
  assign txb.valid = (st_reg == hdl_pkg::ST_SEND) && !issued_reg;
  assign txb.data = msg_pend_reg ? tx_data_reg : 8'h04;
  hdl_uart_tx u_tx (
    .hclk(hclk),
    .hresetn(hresetn),
    .div(baud_div(baud_sel)), // R1
    .par_en(par_en),
    .in(txb),
    .busy(tx_busy),
    .txd(txd)
  );
  assign rts = modem && (st_reg != hdl_pkg::ST_IDLE) && (st_reg != hdl_pkg::ST_PRE); // R3
  // ----------------------------------------------------------------
  // message request, retries, poll timeout
  // ----------------------------------------------------------------
  wire retry_over = no_ack_retry && (retry_reg == retry_max); // R12
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      msg_pend_reg <= 1'b0;
      sent_wait_reg <= 1'b0;
      retry_reg <= 8'h00;
      poll_cnt_reg <= 16'h0000;
    end else begin
      if (do_msg) begin
        msg_pend_reg <= 1'b1;
        retry_reg <= 8'h00;
        sent_wait_reg <= 1'b0;
        poll_cnt_reg <= poll_to_reg; // R6
      end else if (poll_exp || retry_over || (do_ack && sent_wait_reg)) begin
        msg_pend_reg <= 1'b0; // R8 R12 R15
        sent_wait_reg <= 1'b0;
      end else begin
        if (no_ack_retry) retry_reg <= retry_reg + 8'h01; // R12
        if (send_done && msg_pend_reg) sent_wait_reg <= 1'b1;
        if (do_poll) poll_cnt_reg <= poll_to_reg; // R7
        else if (poll_run && tickp) poll_cnt_reg <= poll_cnt_reg - 16'h0001;
      end
    end
  end
  // ----------------------------------------------------------------
  // received packets and duplicate filter
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_data_reg <= 8'h00;
      last_sig_reg <= 16'h0000;
      last_sig_ok_reg <= 1'b0;
    end else if (do_rxpkt && !is_dup) begin
      rx_data_reg <= hwdata[15:8]; // R5
      last_sig_reg <= rx_sig;
      last_sig_ok_reg <= 1'b1;
    end
  end
  // ----------------------------------------------------------------
  // interrupts: set wins over write-one clear
  // ----------------------------------------------------------------
  wire [4:0] ev = {do_rxpkt && !is_dup, do_rxpkt && is_dup, retry_over,
                   send_done && msg_pend_reg, poll_exp};
  wire [4:0] clr = (wr && (wa == hdl_pkg::A_IRQ_STAT)) ? hwdata[4:0] : 5'h00;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) istat_reg <= 5'h00;
    else istat_reg <= (istat_reg & ~clr) | ev;
  end
  assign irq = |(istat_reg & imask_reg);
endmodule

// ### logic/hdl_pkg.sv
package hdl_pkg;
  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_POLL_TO = 8'h04;
  localparam logic [7:0] A_RTS_OFF = 8'h08;
  localparam logic [7:0] A_RTS_SEND = 8'h0C;
  localparam logic [7:0] A_PRE_TX = 8'h10;
  localparam logic [7:0] A_TX_DATA = 8'h14;
  localparam logic [7:0] A_RX_DATA = 8'h18;
  localparam logic [7:0] A_CMD = 8'h1C;
  localparam logic [7:0] A_STATUS = 8'h20;
  localparam logic [7:0] A_IRQ_STAT = 8'h24;
  localparam logic [7:0] A_IRQ_MASK = 8'h28;
  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  localparam int C_BAUD_LSB = 0;
  localparam int C_PAR = 3;
  localparam int C_CHK = 4;
  localparam int C_LINE_LSB = 5;
  localparam int C_EOT_SUP = 7;
  localparam int C_DUP = 8;
  localparam int C_ADDR_LSB = 16;
  localparam int C_RETRY_LSB = 24;
  localparam logic [31:0] CTRL_RST = 32'h0300_0000;
  // ----------------------------------------------------------------
  // command bits
  // ----------------------------------------------------------------
  localparam int K_MSG = 0;
  localparam int K_ACK = 1;
  localparam int K_POLL = 2;
  localparam int K_RXPKT = 3;
  // ----------------------------------------------------------------
  // interrupt bits
  // ----------------------------------------------------------------
  localparam int I_POLL_TO = 0;
  localparam int I_SENT = 1;
  localparam int I_RETRY_FAIL = 2;
  localparam int I_DUP = 3;
  localparam int I_RX = 4;
  localparam int I_W = 5;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 40_000_000;
  localparam int MS_UNIT = 1;
  localparam int MS20_UNIT = 20;
  localparam int CYC_1MS = CLK_HZ / 1000 * MS_UNIT;
  localparam int CYC_20MS = CLK_HZ / 1000 * MS20_UNIT;
  // number of bit rates, 300..38400 baud
  localparam int NBAUD = 8;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    LINE_NONE = 2'b00,
    LINE_MODEM = 2'b01,
    LINE_485 = 2'b10
  } hdl_line_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PRE = 3'b001,
    ST_RTS_WAIT = 3'b010,
    ST_CTS = 3'b011,
    ST_SEND = 3'b100,
    ST_RTS_OFF = 3'b101
  } hdl_st_t;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } hdl_byte_t;
endpackage

// ### logic/hdl_tick.sv
`timescale 1ns/1ps
// strobe every DIV cycles, counted again from zero on restart
module hdl_tick #(
  parameter int DIV = 40000
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic restart,
  output logic tick
);
  logic [19:0] cnt_reg;
  // ----------------------------------------------------------------
  // divider
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg <= 20'h0_0000;
    end else if (restart) begin
      // a fresh delay gets whole units, not a part-spent first one
      cnt_reg <= 20'h0_0000;
    end else if (cnt_reg == 20'(DIV - 1)) begin
      cnt_reg <= 20'h0_0000;
    end else begin
      cnt_reg <= cnt_reg + 20'h0_0001;
    end
  end
  assign tick = (cnt_reg == 20'(DIV - 1));
endmodule

// ### logic/hdl_uart_tx.sv
`timescale 1ns/1ps
// 8 data bits, optional even parity, 1 stop
module hdl_uart_tx (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [17:0] div,
  input wire logic par_en,
  input wire hdl_pkg::hdl_byte_t in,
  output logic busy,
  output logic txd
);
  logic [17:0] cnt_reg;
  logic [3:0] bit_reg;
  logic [10:0] sh_reg;
  logic busy_reg;
  wire [3:0] last_bit = par_en ? 4'hA : 4'h9;
  wire bit_end = busy_reg && (cnt_reg == 18'h0_0000);
  // ----------------------------------------------------------------
  // shifter
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg <= 18'h0_0000;
      bit_reg <= 4'h0;
      sh_reg <= 11'h7FF;
      busy_reg <= 1'b0;
    end else if (!busy_reg && in.valid) begin
      // stop, parity (or stop), data, start
      sh_reg <= {1'b1, par_en ? ^in.data : 1'b1, in.data, 1'b0};
      cnt_reg <= div;
      bit_reg <= 4'h0;
      busy_reg <= 1'b1;
    end else if (bit_end) begin
      sh_reg <= {1'b1, sh_reg[10:1]};
      cnt_reg <= div;
      bit_reg <= bit_reg + 4'h1;
      busy_reg <= (bit_reg != last_bit);
    end else if (busy_reg) begin
      cnt_reg <= cnt_reg - 18'h0_0001;
    end
  end
  assign busy = busy_reg;
  assign txd = busy_reg ? sh_reg[0] : 1'b1;
endmodule

// ### test/hdl_link_chk.sv
`timescale 1ns/1ps
// ------------------------------------------------
// port checker for the slave link
// ------------------------------------------------
module hdl_link_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic cts,
  input wire logic rts,
  input wire logic txd,
  input wire logic irq
);
  logic ap_wr_reg;
  logic [7:0] ap_addr_reg;
  logic [1:0] line_reg;
  // decode of the bus data phase
  wire dp_wr = ap_wr_reg && hready;
  wire modem = line_reg == hdl_pkg::LINE_MODEM;
  wire mask0 = dp_wr && ap_addr_reg == hdl_pkg::A_IRQ_MASK && hwdata == 32'h0000_0000;
  // shadow of the line mode; only bus writes change it, so no access to internals needed
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr_reg <= 1'b0;
      ap_addr_reg <= 8'h00;
      line_reg <= 2'h0;
    end else begin
      if (hready) begin
        ap_wr_reg <= hsel && htrans[1] && hwrite;
        ap_addr_reg <= haddr[7:0];
      end
      if (dp_wr && ap_addr_reg == hdl_pkg::A_CTRL) begin
        line_reg <= hwdata[6:5];
      end
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  bus_okay_a: assert property (hresp == 1'b0)
    else $error("bus answered with an error");
  wait_bound_a: assert property (!hreadyout |-> ##[1:16] hreadyout)
    else $error("bus wait state too long");
  reset_idle_a: assert property ($rose(hresetn) |-> !rts && txd)
    else $error("line not idle after reset");
  plain_no_rts_a: assert property (!modem |-> !rts)
    else $error("rts raised outside modem mode");
  rts_gate_a: assert property (modem && !rts |-> txd)
    else $error("sending without rts in modem mode");
  cts_gate_a: assert property (modem && $fell(txd) |-> $past(cts))
    else $error("sending before clear to send");
  rts_drop_a: assert property ($fell(rts) |-> txd && $past(txd))
    else $error("rts dropped during a character");
  mask_irq_a: assert property (mask0 |-> ##[1:2] !irq)
    else $error("interrupt stays high when masked");
endmodule

bind hdl_link hdl_link_chk hdl_link_chk_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cts(cts),
  .rts(rts), .txd(txd), .irq(irq));

// ### test/hdl_modem_model.sv
`timescale 1ns/1ps
// ------------------------------------------------
// modem: clear to send follows rts after a delay
// ------------------------------------------------
module hdl_modem_model #(
  parameter int DLY = 300
) (
  input wire logic hclk,
  input wire logic rts,
  output logic cts
);
  int cnt;
  initial cts = 1'b0;
  // slow modem, so a design that sends without waiting for cts shows up
  always @(posedge hclk) begin
    if (rts !== 1'b1) begin
      cnt <= 0;
      cts <= 1'b0;
    end else if (cnt < DLY) begin
      cnt <= cnt + 1;
    end else begin
      cts <= 1'b1;
    end
  end
endmodule

// ### test/test_hdl_link.sv
`timescale 1ns/1ps
module test_hdl_link;
  logic hclk, hresetn, hsel, hwrite;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout, hresp, cts, rts, txd, irq;
  logic [31:0] d;
  int n_errors = 0;
  int n_tests = 0;
  hdl_link hdl_link_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cts(cts), .rts(rts),
    .txd(txd), .irq(irq));
  hdl_modem_model #(.DLY(300)) hdl_modem_model_i (.hclk(hclk), .rts(rts), .cts(cts));
  // ------------------------------------------------
  // reporting
  // ------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic finish_test;
    $display("comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ------------------------------------------------
  // bus master and line watchers
  // ------------------------------------------------
  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 64);
    if (hreadyout !== 1'b1) begin
      check("bus ready", 1, hreadyout);
      finish_test();
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    d = hrdata;
  endtask
  // retries kept at 3, node address 0, fastest baud index
  function automatic logic [31:0] ctrl(input logic [1:0] ln, input logic eot, input logic dup);
    return hdl_pkg::CTRL_RST | 32'h7 | ({30'h0, ln} << hdl_pkg::C_LINE_LSB)
      | ({31'h0, eot} << hdl_pkg::C_EOT_SUP) | ({31'h0, dup} << hdl_pkg::C_DUP);
  endfunction
  // counts cycles until the line reaches v; must land inside [lo, hi]
  task automatic watch(input bit on_rts, input logic v, input int lo, input int hi,
                       input string what);
    int n;
    n = 0;
    while ((on_rts ? rts : txd) !== v && n <= hi) begin
      @(posedge hclk);
      n++;
    end
    check(what, 1, n >= lo && n <= hi);
    if (n > hi) finish_test();
  endtask
  // waits for a long idle stretch so no reply spills into the next test
  task automatic idle_wait;
    int n, q;
    q = 0;
    for (n = 0; n < 200000 && q < 12000; n++) begin
      @(posedge hclk);
      q = (txd === 1'b1) ? q + 1 : 0;
    end
    check("line idle", 1, q >= 12000);
    if (q < 12000) finish_test();
  endtask
  // ------------------------------------------------
  // scenarios
  // ------------------------------------------------
  task automatic t_reset;
    bus(0, hdl_pkg::A_CTRL, 0);
    check("control reset", hdl_pkg::CTRL_RST, d);
    bus(0, hdl_pkg::A_IRQ_STAT, 0);
    check("status reset", 0, d);
    check("rts idle", 0, rts);
    check("txd idle", 1, txd);
    check("irq idle", 0, irq);
    bus(0, 8'h3C, 0);
    check("unmapped response", 0, hresp);
    $display("test done: reset values");
  endtask
  task automatic t_dup;
    bus(1, hdl_pkg::A_CTRL, ctrl(hdl_pkg::LINE_NONE, 0, 1));
    bus(1, hdl_pkg::A_IRQ_MASK, 32'h1 << hdl_pkg::I_DUP);
    bus(1, hdl_pkg::A_RX_DATA, 32'h5A);
    bus(1, hdl_pkg::A_CMD, 32'h1 << hdl_pkg::K_RXPKT);
    bus(0, hdl_pkg::A_IRQ_STAT, 0);
    check("first packet dup", 0, d[hdl_pkg::I_DUP]);
    bus(1, hdl_pkg::A_CMD, 32'h1 << hdl_pkg::K_RXPKT);
    repeat (4) @(posedge hclk);
    bus(0, hdl_pkg::A_IRQ_STAT, 0);
    check("repeat packet dup", 1, d[hdl_pkg::I_DUP]);
    check("irq raised", 1, irq);
    bus(1, hdl_pkg::A_IRQ_MASK, 0);
    repeat (2) @(posedge hclk);
    check("irq masked", 0, irq);
    bus(1, hdl_pkg::A_IRQ_MASK, 32'h1 << hdl_pkg::I_DUP);
    repeat (2) @(posedge hclk);
    check("irq unmasked", 1, irq);
    bus(1, hdl_pkg::A_IRQ_STAT, 32'h1 << hdl_pkg::I_DUP);
    repeat (2) @(posedge hclk);
    check("irq cleared", 0, irq);
    bus(1, hdl_pkg::A_CTRL, ctrl(hdl_pkg::LINE_NONE, 0, 0));
    bus(1, hdl_pkg::A_CMD, 32'h1 << hdl_pkg::K_RXPKT);
    repeat (4) @(posedge hclk);
    bus(0, hdl_pkg::A_IRQ_STAT, 0);
    check("dup detect off", 0, d[hdl_pkg::I_DUP]);
    $display("test done: duplicate packets");
  endtask
  task automatic t_eot;
    int n;
    bus(1, hdl_pkg::A_PRE_TX, 0);
    bus(1, hdl_pkg::A_CTRL, ctrl(hdl_pkg::LINE_NONE, 1, 0));
    bus(1, hdl_pkg::A_CMD, 32'h1 << hdl_pkg::K_POLL);
    n = 0;
    repeat (12000) begin
      @(posedge hclk);
      n += (txd !== 1'b1);
    end
    check("suppressed reply", 0, n);
    bus(1, hdl_pkg::A_PRE_TX, 1);
    bus(1, hdl_pkg::A_CTRL, ctrl(hdl_pkg::LINE_NONE, 0, 0));
    bus(1, hdl_pkg::A_CMD, 32'h1 << hdl_pkg::K_POLL);
    watch(0, 0, hdl_pkg::CYC_1MS - 8, hdl_pkg::CYC_1MS + 2000, "pre-transmit delay");
    idle_wait();
    $display("test done: poll replies");
  endtask
  task automatic t_modem;
    bus(1, hdl_pkg::A_PRE_TX, 0);
    bus(1, hdl_pkg::A_RTS_OFF, 0);
    bus(1, hdl_pkg::A_RTS_SEND, 0);
    bus(1, hdl_pkg::A_CTRL, ctrl(hdl_pkg::LINE_MODEM, 0, 0));
    bus(1, hdl_pkg::A_TX_DATA, 32'h33);
    bus(1, hdl_pkg::A_CMD, 32'h1 << hdl_pkg::K_MSG);
    bus(1, hdl_pkg::A_CMD, 32'h1 << hdl_pkg::K_POLL);
    watch(1, 1, 0, 2000, "rts raised");
    watch(0, 0, 300, 2300, "start after cts");
    watch(1, 0, 0, 150000, "rts released");
    bus(1, hdl_pkg::A_CMD, 32'h1 << hdl_pkg::K_ACK);
    idle_wait();
    check("rts after ack", 0, rts);
    $display("test done: modem handshake");
  endtask
  // ------------------------------------------------
  // clock, reset and sequence
  // ------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_dup();
    t_eot();
    t_modem();
    finish_test();
  end
endmodule
